// ### include/bpm_map.vh
`ifndef BPM_MAP_VH
`define BPM_MAP_VH
`define BPM_ADDR_W      22
`define BPM_DATA_W      16
`define BPM_BAD_LO      16
`define BPM_BAD_HI      17
`define BPM_SREG_LO     5
`define BPM_SREG_HI     12
`define BPM_ROW_W       8
`define BPM_COL_LO      8
`define BPM_REFRESH_CYC 16'h0040
`define BPM_ACCESS_CYC  4'h3
`define BPM_REFRESH_LEN 4'h4
`define BPM_SREG_MATCH  8'h44
`define BPM_SREG_RST    16'h0000
`define BPM_WORDS_LOG2  10
`define BPM_BASE        22'h000000
`endif

// ### core/bpm_slave.v
// Notes on behaviour
// - memory is only ever a bus slave
// - word read, word/byte write, read-modify-write cycles
// - address, then data, then termination phases
// - capture all 22 address lines on sync
// - write data taken from lines 15..0
// - lines 16, 17 flag bad read word
// - write/byte line in address phase: write/read
// - write/byte in data phase: byte, bit0 picks
// - io page: status register decode, array off
// - memory space: array decode, status off
// - sync latches address, row, column, request
// - input strobe: drive bus, reply with data
// - output strobe raises arbitrated write request
// - every array access arbitrates against refresh first; status register accesses skip it
// - reply answers input or output strobe
// - two parity bits stored with each word
// - output strobe drop, then reply drops
`timescale 1ns/100ps
`include "bpm_map.vh"
module bpm_slave #(
  parameter WORDS_LOG2 = `BPM_WORDS_LOG2,
  parameter [`BPM_ADDR_W-1:0] BASE = `BPM_BASE,
  parameter [15:0] REFRESH_CYC = `BPM_REFRESH_CYC
) (
  input  wire                    clk,
  input  wire                    rst,
  input  wire [`BPM_ADDR_W-1:0]  dal_in,
  output reg  [`BPM_ADDR_W-1:0]  dal_out,
  output reg                     dal_oe,
  input  wire                    sync,
  input  wire                    din,
  input  wire                    dout,
  input  wire                    wtbt,
  input  wire                    bs7,
  output reg                     rply,
  output reg                     io_page_select,
  output reg                     array_selected,
  output reg                     refresh_busy
);
  // all bus lines are active high here; pad inversion sits outside
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_ARB  = 3'h2;
  localparam ST_ACC  = 3'h3;
  localparam ST_RPLY = 3'h4;
  localparam ST_WAIT = 3'h5;

  reg [17:0]              mem [0:(1<<WORDS_LOG2)-1];
  reg [2:0]               state;
  reg                     sync_d;

  // address, row, column, requests and write flag latched on the first edge of a cycle; byte flag and sreg later
  reg [`BPM_ADDR_W-1:0]   addr;
  reg [`BPM_ROW_W-1:0]    row;
  reg [`BPM_ADDR_W-`BPM_COL_LO-1:0] col;
  reg                     rd_req;
  reg                     wr_req;
  reg                     is_write;
  reg                     is_byte;
  reg [15:0]              sreg;

  // refresh and access timing
  reg [15:0]              ref_cnt;
  reg [3:0]               ref_left;
  reg                     ref_pend;
  reg [3:0]               acc_cnt;

  // data path
  reg                     did_read;
  reg [15:0]              wdata;
  reg [17:0]              rword;
  reg [17:0]              cur;
  reg                     in_array;
  reg                     io_hit;
  reg [`BPM_ADDR_W-1:0]   next_dal_out;
  wire [17:0]             next_sreg_word;
  wire                    ram_grant;

  function [1:0] parity2;
    input [15:0] d;
    begin
      parity2 = {^d[15:8], ^d[7:0]};
    end
  endfunction

  function [17:0] merge;
    input [17:0] old;
    input [15:0] d;
    input        byte_op;
    input        hi;
    reg   [15:0] m;
    begin
      m = old[15:0];
      if (!byte_op)
        m = d;
      else if (hi)
        m[15:8] = d[15:8];
      else
        m[7:0] = d[7:0];
      merge = {parity2(m), m};
    end
  endfunction

  // both flags up means the stored parity no longer fits the word
  function [1:0] bad_flags;
    input [17:0] w;
    begin
      bad_flags = {2{parity2(w[15:0]) != w[17:16]}};
    end
  endfunction

  function io_match;
    input [`BPM_ADDR_W-1:0] a;
    input                   sel7;
    begin
      io_match = sel7 && (a[`BPM_SREG_HI:`BPM_SREG_LO] == `BPM_SREG_MATCH);
    end
  endfunction

  // base compare plus an all-zero top slice keeps the window power-of-two sized
  function array_match;
    input [`BPM_ADDR_W-1:0] a;
    input                   sel7;
    reg   [`BPM_ADDR_W-1:0] rel;
    begin
      rel         = a - BASE;
      array_match = !sel7 && (a >= BASE) &&
                    (rel[`BPM_ADDR_W-1:WORDS_LOG2+1] == 0);
    end
  endfunction

  wire [WORDS_LOG2-1:0] widx = addr[WORDS_LOG2:1];

  // status register reuses the array merge; its parity bits are dropped
  assign next_sreg_word = merge({2'b00, sreg}, wdata, is_byte, addr[0]);
  // a ram access starts only with a pending request and no refresh in sight
  assign ram_grant      = (rd_req || wr_req) && !refresh_busy && !ref_pend;

  always @* begin
    // decode is mutually exclusive on the bank-7 line
    io_hit   = io_match(dal_in, bs7);
    in_array = array_match(dal_in, bs7);
  end

  always @* begin
    // health flags sit just above the word; upper lines stay low
    next_dal_out = {{(`BPM_ADDR_W-`BPM_BAD_HI-1){1'b0}}, bad_flags(rword), rword[15:0]};
  end

  always @(posedge clk) begin
    if (rst) begin
      ref_cnt  <= 16'h0000;
      ref_pend <= 1'b0;
    end else if (ref_cnt == REFRESH_CYC - 16'h0001) begin
      ref_cnt  <= 16'h0000;
      ref_pend <= 1'b1;
    end else begin
      ref_cnt <= ref_cnt + 16'h0001;
      if (refresh_busy)
        ref_pend <= 1'b0;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      refresh_busy <= 1'b0;
      ref_left     <= 4'h0;
    end else if (refresh_busy) begin
      ref_left <= ref_left - 4'h1;
      if (ref_left == 4'h1)
        refresh_busy <= 1'b0;
    end else if (ref_pend && state != ST_ACC) begin
      // refresh wins only when no ram access is under way
      refresh_busy <= 1'b1;
      ref_left     <= `BPM_REFRESH_LEN;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      state          <= ST_IDLE;
      sync_d         <= 1'b0;
      addr           <= {`BPM_ADDR_W{1'b0}};
      row            <= {`BPM_ROW_W{1'b0}};
      col            <= {(`BPM_ADDR_W-`BPM_COL_LO){1'b0}};
      rd_req         <= 1'b0;
      wr_req         <= 1'b0;
      is_write       <= 1'b0;
      is_byte        <= 1'b0;
      sreg           <= `BPM_SREG_RST;
      acc_cnt        <= 4'h0;
      did_read       <= 1'b0;
      wdata          <= 16'h0000;
      rword          <= 18'h00000;
      cur            <= 18'h00000;
      dal_out        <= {`BPM_ADDR_W{1'b0}};
      dal_oe         <= 1'b0;
      rply           <= 1'b0;
      io_page_select <= 1'b0;
      array_selected <= 1'b0;
    end else begin
      sync_d <= sync;
      if (!sync) begin
        // termination: master dropped sync, all selects go away
        state          <= ST_IDLE;
        rd_req         <= 1'b0;
        wr_req         <= 1'b0;
        did_read       <= 1'b0;
        dal_oe         <= 1'b0;
        rply           <= 1'b0;
        io_page_select <= 1'b0;
        array_selected <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            if (!sync_d) begin
              addr           <= dal_in;
              row            <= dal_in[`BPM_ROW_W:1];
              col            <= dal_in[`BPM_ADDR_W-1:`BPM_COL_LO];
              is_write       <= wtbt;
              rd_req         <= !wtbt;
              wr_req         <= 1'b0;
              io_page_select <= io_hit;
              array_selected <= in_array;
              state          <= ST_ADDR;
            end
          end

          ST_ADDR: begin
            // never drives anything unless selected: slave only
            // one read per cycle, and only a cycle opened as a read may read
            if (din && !is_write && !did_read && (array_selected || io_page_select)) begin
              rd_req <= 1'b1;
              is_byte <= 1'b0;
              state  <= ST_ARB;
            end else if (dout && (is_write || did_read) && (array_selected || io_page_select)) begin
              wdata   <= dal_in[`BPM_DATA_W-1:0];
              is_byte <= wtbt;
              wr_req  <= 1'b1;
              rd_req  <= 1'b0;
              state   <= ST_ARB;
            end
          end

          ST_ARB: begin
            if (io_page_select) begin
              if (wr_req)
                sreg <= next_sreg_word[15:0];
              rword <= {parity2(sreg), sreg};
              state <= ST_RPLY;
            end else if (ram_grant) begin
              cur     <= mem[widx];
              acc_cnt <= `BPM_ACCESS_CYC;
              state   <= ST_ACC;
            end
          end

          ST_ACC: begin
            acc_cnt <= acc_cnt - 4'h1;
            if (acc_cnt == 4'h1) begin
              if (wr_req)
                mem[widx] <= merge(cur, wdata, is_byte, addr[0]);
              rword <= cur;
              state <= ST_RPLY;
            end
          end

          ST_RPLY: begin
            if (!wr_req) begin
              dal_out <= next_dal_out;
              dal_oe  <= 1'b1;
              did_read <= 1'b1;
            end
            rply  <= 1'b1;
            state <= ST_WAIT;
          end

          ST_WAIT: begin
            if (wr_req && !dout) begin
              rply   <= 1'b0;
              wr_req <= 1'b0;
              state  <= ST_ADDR;                                          // second half of read-modify-write
            end else if (!wr_req && !din) begin
              rply   <= 1'b0;
              dal_oe <= 1'b0;
              rd_req <= 1'b0;
              state  <= ST_ADDR;
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end
endmodule // bpm_slave

// ### verification/bpm_slave_props.sv
`timescale 1ns/100ps
`include "bpm_map.vh"
module bpm_slave_chk #(
  parameter WORDS_LOG2 = 10,
  parameter [`BPM_ADDR_W-1:0] BASE = 0
) (
  input wire                   clk,
  input wire                   rst,
  input wire [`BPM_ADDR_W-1:0] dal_in,
  input wire [`BPM_ADDR_W-1:0] dal_out,
  input wire                   dal_oe,
  input wire                   sync,
  input wire                   din,
  input wire                   dout,
  input wire                   wtbt,
  input wire                   bs7,
  input wire                   rply,
  input wire                   io_page_select,
  input wire                   array_selected,
  input wire                   refresh_busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  slave_only_a: assert property (dal_oe |-> $past(sync)) else $error("drivers on outside a cycle");
  read_drive_a: assert property (rply && din |-> dal_oe) else $error("read reply without drivers");
  reply_cause_a: assert property (rply |-> $past(din || dout)) else $error("reply without strobe");
  write_drop_a: assert property ($fell(dout) |=> !rply) else $error("reply held after write strobe");
  read_drop_a: assert property ($fell(din) |=> !rply && !dal_oe) else $error("read not released");
  bad_pair_a: assert property (dal_oe |-> dal_out[17] == dal_out[16]) else $error("bad flags differ");
  sel_excl_a: assert property (!(io_page_select && array_selected)) else $error("both decodes on");
  io_decode_a: assert property ($rose(sync) && bs7 && dal_in[12:5] == 8'h44 |-> ##[1:2] io_page_select)
    else $error("status decode missed");
  mem_decode_a: assert property ($rose(sync) && !bs7 && ((dal_in - BASE) >> (WORDS_LOG2 + 1)) == 0
    |-> ##[1:2] array_selected) else $error("array decode missed");
  arb_wait_a: assert property ($rose(din) && array_selected |-> !rply [*4]) else $error("reply too early");
  refresh_len_a: assert property ($rose(refresh_busy) |-> refresh_busy [*4] ##1 !refresh_busy)
    else $error("refresh length wrong");
  ref_c: cover property (refresh_busy && din && !rply);
  rd_c: cover property (rply && din);
  wr_c: cover property (rply && dout);
  io_c: cover property (io_page_select && rply);
endmodule // bpm_slave_chk
bind bpm_slave bpm_slave_chk #(.WORDS_LOG2(WORDS_LOG2), .BASE(BASE)) u_chk (.clk(clk), .rst(rst),
  .dal_in(dal_in), .dal_out(dal_out), .dal_oe(dal_oe), .sync(sync), .din(din), .dout(dout), .wtbt(wtbt),
  .bs7(bs7), .rply(rply), .io_page_select(io_page_select), .array_selected(array_selected),
  .refresh_busy(refresh_busy));

// ### verification/bpm_master.sv
`timescale 1ns/100ps
module bpm_master (
  input  wire        clk,
  input  wire        rply,
  input  wire [21:0] dal_out,
  output reg  [21:0] dal_in,
  output reg         sync,
  output reg         din,
  output reg         dout,
  output reg         wtbt,
  output reg         bs7
);
  initial begin
    dal_in = 22'h3fffff;
    {sync, din, dout, wtbt, bs7} = 5'h00;
  end
  task wait_rply(input v, output ok);
    integer i;
    begin
      ok = 0;
      for (i = 0; i < 40 && !ok; i = i + 1) begin
        @(posedge clk);
        ok = (rply === v);
      end
      #1;
    end
  endtask
  task xfer(input [21:0] a, input io, rp, wp, byt, input [15:0] wd, output [17:0] rd, output ok);
    reg k;
    begin
      rd = 18'h0;
      wait_rply(1'b0, k);
      dal_in = a;
      bs7 = io;
      wtbt = wp & ~rp;
      @(posedge clk) #1 sync = 1;
      @(posedge clk) #1 bs7 = 0;
      ok = 1;
      if (rp) begin
        dal_in = ~a; // released lines show no stale address
        din = 1;
        wait_rply(1'b1, ok);
        rd = dal_out[17:0];
        din = 0;
        wait_rply(1'b0, k);
      end
      if (wp && ok) begin
        dal_in = {~a[21:16], wd};
        wtbt = byt;
        @(posedge clk) #1 dout = 1;
        wait_rply(1'b1, ok);
        dout = 0;
        dal_in = ~dal_in;
        wtbt = 0;
        wait_rply(1'b0, k);
      end
      sync = 0;
      @(posedge clk) #1;
    end
  endtask
endmodule // bpm_master

// ### verification/bpm_slave_tb.sv
`timescale 1ns/100ps
module bpm_slave_tb;
  reg         clk = 0;
  reg         rst = 1;
  wire [21:0] dal_in;
  wire [21:0] dal_out;
  wire        dal_oe, sync, din, dout, wtbt, bs7, rply;
  integer     n_mismatch = 0;
  integer     cmp_count = 0;
  reg  [17:0] rd;
  reg         ok;
  always #50 clk = ~clk;
  bpm_slave DUT (.clk(clk), .rst(rst), .dal_in(dal_in), .dal_out(dal_out), .dal_oe(dal_oe), .sync(sync),
    .din(din), .dout(dout), .wtbt(wtbt), .bs7(bs7), .rply(rply), .io_page_select(), .array_selected(),
    .refresh_busy());
  bpm_master u_m (.clk(clk), .rply(rply), .dal_out(dal_out), .dal_in(dal_in), .sync(sync), .din(din),
    .dout(dout), .wtbt(wtbt), .bs7(bs7));
  task check(input string what, input [17:0] seen, input [17:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("Error %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task finish_test;
    begin
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task t_word_byte;
    begin
      u_m.xfer(22'h000010, 0, 0, 1, 0, 16'ha5c3, rd, ok);
      check("write ack", ok, 1);
      u_m.xfer(22'h000011, 0, 0, 1, 1, 16'h7e00, rd, ok);
      u_m.xfer(22'h000010, 0, 0, 1, 1, 16'h0011, rd, ok);
      u_m.xfer(22'h000010, 0, 1, 0, 0, 16'h0, rd, ok);
      check("byte merge", rd, 18'h07e11);
      $display("done word and byte");
    end
  endtask
  task t_rmw;
    begin
      u_m.xfer(22'h000020, 0, 0, 1, 0, 16'h1111, rd, ok);
      u_m.xfer(22'h000020, 0, 1, 1, 0, 16'h2222, rd, ok);
      check("rmw old", rd, 18'h01111);
      u_m.xfer(22'h000021, 0, 1, 1, 1, 16'h3300, rd, ok);
      check("rmwb old", rd, 18'h02222);
      u_m.xfer(22'h000020, 0, 1, 0, 0, 16'h0, rd, ok);
      check("rmwb new", rd, 18'h03322);
      $display("done rmw");
    end
  endtask
  task t_io;
    begin
      u_m.xfer(22'h3f0880, 1, 0, 1, 0, 16'hbeef, rd, ok);
      u_m.xfer(22'h3f0880, 1, 1, 0, 0, 16'h0, rd, ok);
      check("status reg", rd, 18'h0beef);
      u_m.xfer(22'h3f0000, 1, 1, 0, 0, 16'h0, rd, ok);
      check("io miss", ok, 0);
      u_m.xfer(22'h100000, 0, 1, 0, 0, 16'h0, rd, ok);
      check("mem miss", ok, 0);
      $display("done io and decode");
    end
  endtask
  initial begin
    repeat (20) @(posedge clk);
    #1 rst = 0;
    t_word_byte;
    t_rmw;
    t_io;
    finish_test;
  end
  initial begin
    #2000000;
    n_mismatch = n_mismatch + 1;
    finish_test;
  end
endmodule // bpm_slave_tb
